// >>> bench/gpib_bus_command_decoder_chk.sv
// checker: port-level properties of the bus decoder
`timescale 1ns/1ns
module gpib_bus_command_decoder_chk (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       ifc_n,
  input wire logic       ren_n,
  input wire logic       dav_n,
  input wire logic       nrfd_n_oe,
  input wire logic       ndac_n_oe,
  input wire logic       srq_n_oe,
  input wire logic [4:0] primary_addr,
  input wire logic       serviced,
  input wire logic       remote,
  input wire logic       local_lockout,
  input wire logic       listen_addr,
  input wire logic       talk_addr,
  input wire logic       serial_poll,
  input wire logic       clear_pulse,
  input wire logic       trigger_pulse,
  input wire logic       data_valid
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // long enough to cover pin synchroniser latency
  sequence s_ifc_held;
    !ifc_n [*8];
  endsequence
  sequence s_ren_off;
    ren_n [*8];
  endsequence

  property p_ifc_idle;
    s_ifc_held |-> !listen_addr && !talk_addr;
  endproperty
  a_ifc_idle: assert property (p_ifc_idle)
    else $error("addressing kept under interface clear");

  property p_ren_off;
    s_ren_off |-> !(remote | local_lockout | listen_addr | talk_addr
                    | serial_poll);
  endproperty
  a_ren_off: assert property (p_ren_off)
    else $error("flags kept with remote enable false");

  property p_ndac_rel;
    $rose(ndac_n_oe) |-> !dav_n;
  endproperty
  a_ndac_rel: assert property (p_ndac_rel)
    else $error("accept released without valid data");

  property p_nrfd_rel;
    $rose(nrfd_n_oe) |-> dav_n;
  endproperty
  a_nrfd_rel: assert property (p_nrfd_rel)
    else $error("ready released while data still valid");

  property p_clr_one;
    clear_pulse |=> !clear_pulse;
  endproperty
  a_clr_one: assert property (p_clr_one)
    else $error("clear pulse longer than one cycle");

  property p_trg_one;
    trigger_pulse |=> !trigger_pulse;
  endproperty
  a_trg_one: assert property (p_trg_one)
    else $error("trigger pulse longer than one cycle");

  property p_data_lsn;
    data_valid |-> listen_addr;
  endproperty
  a_data_lsn: assert property (p_data_lsn)
    else $error("data strobe while not listening");

  property p_srq_hold;
    !srq_n_oe && !serviced && !$past(serviced) |=> !srq_n_oe;
  endproperty
  a_srq_hold: assert property (p_srq_hold)
    else $error("service request dropped before service");

  property p_addr_chg;
    $changed(primary_addr) |-> ##[1:8] !listen_addr && !talk_addr;
  endproperty
  a_addr_chg: assert property (p_addr_chg)
    else $error("addressing kept after address change");
endmodule : gpib_bus_command_decoder_chk

bind gpib_bus_command_decoder gpib_bus_command_decoder_chk i_chk (
  .sys_clk, .rst, .ifc_n, .ren_n, .dav_n, .nrfd_n_oe, .ndac_n_oe,
  .srq_n_oe, .primary_addr, .serviced, .remote, .local_lockout,
  .listen_addr, .talk_addr, .serial_poll, .clear_pulse,
  .trigger_pulse, .data_valid);

// >>> bench/gpib_bus_command_decoder_tb_top.sv
// testbench: decoder driven through a controller model
`timescale 1ns/1ns
module gpib_bus_command_decoder_tb_top;
  logic       sys_clk = 1'b0;      // 50 MHz
  logic       rst = 1'b1;          // sync, active high
  logic       ifc_n = 1'b1;        // interface clear pin
  logic       ren_n = 1'b1;        // remote enable pin
  logic [4:0] primary_addr = 5'h18;
  logic       need_service = 1'b0;
  logic       serviced = 1'b0;
  logic       sink_ready = 1'b1;
  logic       lockout_cfg = 1'b1;
  logic       gtl_unlocks = 1'b1;
  logic       trig_any = 1'b0;     // addressed trigger only
  logic [7:0] dio_n, data_byte;
  logic       atn_n, eoi_n, dav_n, data_end, data_valid;
  logic       nrfd_n_out, nrfd_n_oe, ndac_n_out, ndac_n_oe;
  logic       srq_n_out, srq_n_oe, remote, local_lockout;
  logic       panel_locked, local_key_off, listen_addr, talk_addr;
  logic       serial_poll, clear_pulse, trigger_pulse;
  logic [8:0] last_dv;             // end flag and byte
  logic [7:0] mla, mta;            // own listen and talk bytes
  int         err_total = 0, checks = 0;
  int         n_clr = 0, n_trg = 0, n_dv = 0, c, t;
  // open-drain pins with bus pull-ups
  wire        nrfd_n = nrfd_n_oe ? 1'b1 : nrfd_n_out;
  wire        ndac_n = ndac_n_oe ? 1'b1 : ndac_n_out;

  assign mla = 8'h20 | {3'h0, primary_addr};
  assign mta = 8'h40 | {3'h0, primary_addr};

  always #10 sys_clk = ~sys_clk;

  // count one-cycle pulses and capture data
  always @(posedge sys_clk)
  begin
    if (clear_pulse === 1'b1)
      n_clr <= n_clr + 1;
    if (trigger_pulse === 1'b1)
      n_trg <= n_trg + 1;
    if (data_valid === 1'b1)
    begin
      n_dv <= n_dv + 1;
      last_dv <= {data_end, data_byte};
    end
  end

  gpib_ctrl_model i_gpib_ctrl_model (.sys_clk, .nrfd_n, .ndac_n,
    .dio_n, .atn_n, .eoi_n, .dav_n);

  gpib_bus_command_decoder i_gpib_bus_command_decoder (.sys_clk, .rst,
    .dio_n_in(dio_n), .atn_n, .ifc_n, .ren_n, .eoi_n_in(eoi_n), .dav_n,
    .nrfd_n_out, .nrfd_n_oe, .ndac_n_out, .ndac_n_oe, .srq_n_out,
    .srq_n_oe, .primary_addr, .lockout_cfg, .gtl_unlocks, .trig_any,
    .need_service, .serviced, .sink_ready, .remote, .local_lockout,
    .panel_locked, .local_key_off, .listen_addr, .talk_addr,
    .serial_poll, .clear_pulse, .trigger_pulse, .data_byte,
    .data_valid, .data_end);

  task automatic summarize;
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one byte; a hung handshake ends the run
  task automatic snd(input logic [7:0] b, input logic a = 1'b1,
                     input logic e = 1'b0);
    logic ok;
    i_gpib_ctrl_model.xfer(b, a, e, ok);
    chk(ok, 1'b1);
    if (ok !== 1'b1)
      summarize();
    repeat (3) @(posedge sys_clk);
    #2;
  endtask : snd

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : wt

  task automatic t_addr;
    snd(8'h3f);
    snd(mla | 8'h80);
    chk(listen_addr, 1);
    snd(mta);
    chk(talk_addr, 1);
    snd(8'h43);
    chk(talk_addr, 0);
    snd(mta);
    snd(8'h5f);
    chk(talk_addr, 0);
    snd(8'h3f);
    chk(listen_addr, 0);
  endtask : t_addr

  task automatic t_univ;
    snd(8'h11);
    chk({local_lockout, panel_locked, local_key_off}, 9'h7);
    snd(8'h18);
    chk(serial_poll, 1);
    snd(8'h19);
    chk(serial_poll, 0);
    c = n_clr;
    snd(8'h14);
    chk(9'(n_clr - c), 1);
  endtask : t_univ

  task automatic t_acg;
    logic [7:0] ign [4] = '{8'h78, 8'h05, 8'h15, 8'h09};
    c = n_clr;
    t = n_trg;
    snd(8'h04);
    snd(8'h08);
    chk(9'(n_clr - c + n_trg - t), 0);
    snd(mla);
    snd(8'h08);
    chk(9'(n_trg - t), 1);
    snd(8'h04);
    chk(9'(n_clr - c), 1);
    snd(mla);
    foreach (ign[i])
      snd(ign[i]);
    chk({listen_addr, 8'(n_clr - c + n_trg - t)}, 9'h102);
    snd(8'h11);
    snd(8'h01);
    chk(local_lockout, 0);
    chk({remote, panel_locked}, 9'h0);
  endtask : t_acg

  // a stalled sink must hold the transfer off
  task automatic t_data;
    snd(mla);
    chk(remote, 1);
    sink_ready = 1'b0;
    c = n_dv;
    fork
      snd(8'h52, 1'b0);
      begin
        wt(20);
        chk(9'(n_dv - c), 0);
        sink_ready = 1'b1;
      end
    join
    chk(last_dv, 9'h052);
    snd(8'h53, 1'b0, 1'b1);
    chk(last_dv, 9'h153);
  endtask : t_data

  task automatic t_misc;
    snd(mta);
    ifc_n = 1'b0;
    wt(10);
    ifc_n = 1'b1;
    chk({listen_addr, talk_addr}, 0);
    t = n_trg;
    trig_any = 1'b1;
    snd(8'h08);
    trig_any = 1'b0;
    chk(9'(n_trg - t), 1);
    need_service = 1'b1;
    wt(1);
    need_service = 1'b0;
    wt(10);
    chk(srq_n_oe, 0);
    serviced = 1'b1;
    wt(1);
    serviced = 1'b0;
    wt(5);
    chk(srq_n_oe, 1);
    snd(mla);
    primary_addr = 5'h1f;
    wt(8);
    chk(listen_addr, 0);
    snd(8'h3e);
    chk(listen_addr, 1);
    ren_n = 1'b1;
    wt(10);
    chk({remote, local_lockout, listen_addr, serial_poll}, 0);
  endtask : t_misc

  initial
  begin
    wt(10);
    rst = 1'b0;
    wt(5);
    ren_n = 1'b0;
    wt(10);
    chk({remote, panel_locked}, 9'h3);
    t_addr();
    t_univ();
    t_acg();
    t_data();
    t_misc();
    summarize();
  end
endmodule : gpib_bus_command_decoder_tb_top

// >>> bench/gpib_ctrl_model.sv
// controller model: sends bytes with the three-wire handshake
`timescale 1ns/1ns
module gpib_ctrl_model (
  input  wire logic       sys_clk, // system clock
  input  wire logic       nrfd_n,  // resolved not-ready pin
  input  wire logic       ndac_n,  // resolved not-accepted pin
  output logic [7:0]      dio_n,   // data pins, low-true
  output logic            atn_n,   // attention, controller only
  output logic            eoi_n,   // end marker
  output logic            dav_n    // data valid
);
  // idle bus: everything released
  initial
  begin
    dio_n = 8'hff;
    atn_n = 1'b1;
    eoi_n = 1'b1;
    dav_n = 1'b1;
  end

  // one byte; ok low if the acceptor never answers
  task automatic xfer(input logic [7:0] b, input logic a,
                      input logic e, output logic ok);
    int   n;
    logic rdy;
    @(posedge sys_clk);
    #2;
    atn_n = ~a;
    dio_n = ~b;
    eoi_n = ~e;
    // settle time so attention is seen before the strobe
    repeat (6) @(posedge sys_clk);
    for (n = 0; n < 200 && nrfd_n !== 1'b1; n++)
      @(posedge sys_clk);
    rdy = nrfd_n;
    #2;
    dav_n = 1'b0;
    for (n = 0; n < 200 && ndac_n !== 1'b1; n++)
      @(posedge sys_clk);
    ok = rdy & ndac_n;
    #2;
    dav_n = 1'b1;
    // released data lines float back to the pull-up level
    dio_n = 8'hff;
    eoi_n = 1'b1;
  endtask : xfer
endmodule : gpib_ctrl_model

// >>> logic/gpib_bus_command_decoder.sv
// file: listener-side bus command decoder with acceptor handshake
`timescale 1ns/1ns

// Summary of operation
// - only controller drives attention, clear, remote lines
// - remote enable rising, or own listen with it true, sets remote mode
// - end line marks final byte of message
// - interface clear drops talk and listen addressing
// - bytes under attention decode as commands
// - service request held until serviced
// - lockout byte sets local lockout unaddressed
// - device clear byte resets to defaults
// - poll bytes enter and leave serial poll
// - addressed commands act only when listening, trigger also with trig_any
// - selective clear resets only listening device
// - go-to-local leaves remote when listening
// - trigger byte fires action when listening
// - own listen address sets listen state
// - own talk address talks, other drops it
// - secondary address bytes are ignored
// - unlisten byte clears listen state
// - untalk byte clears talk state
// - data bytes while listening go out
// - parallel poll and take control ignored
// - bus lines low-true, inverted inside
// - hold not-accepted low until byte taken
// - address limited 0..30, change resets interface
module gpib_bus_command_decoder (
  input  wire logic       sys_clk,        // 50 MHz system clock
  input  wire logic       rst,            // synchronous, active high
  input  wire logic [7:0] dio_n_in,       // data pins, low-true
  input  wire logic       atn_n,          // attention pin
  input  wire logic       ifc_n,          // interface clear pin
  input  wire logic       ren_n,          // remote enable pin
  input  wire logic       eoi_n_in,       // end-or-identify pin
  input  wire logic       dav_n,          // data valid pin
  output logic            nrfd_n_out,     // not ready for data drive
  output logic            nrfd_n_oe,      // low while driven
  output logic            ndac_n_out,     // not data accepted drive
  output logic            ndac_n_oe,      // low while driven
  output logic            srq_n_out,      // service request drive
  output logic            srq_n_oe,       // low while driven
  input  wire logic [4:0] primary_addr,   // configured primary address
  input  wire logic       lockout_cfg,    // lock panel while remote
  input  wire logic       gtl_unlocks,    // go-to-local clears lockout
  input  wire logic       trig_any,       // trigger without addressing
  input  wire logic       need_service,   // instrument wants service
  input  wire logic       serviced,       // status byte was read
  input  wire logic       sink_ready,     // message input can take a byte
  output logic            remote,         // remote mode
  output logic            local_lockout,  // lockout state
  output logic            panel_locked,   // panel controls disabled
  output logic            local_key_off,  // local key disabled
  output logic            listen_addr,    // listen-addressed
  output logic            talk_addr,      // talk-addressed
  output logic            serial_poll,    // serial poll mode active
  output logic            clear_pulse,    // device clear, one cycle
  output logic            trigger_pulse,  // trigger action, one cycle
  output logic [7:0]      data_byte,      // data byte to parser
  output logic            data_valid,     // data strobe, one cycle
  output logic            data_end        // byte carried end flag
);

  // synchroniser chains for all bus inputs
  localparam int sync_w = 13;
  logic [sync_w-1:0] s1_q, s2_q, s3_q;   // stage 1 read only by stage 2
  logic [sync_w-1:0] raw;               // pin levels, true-high
  logic [sync_w-1:0] stable_q;          // agreed level

  assign raw = {~dio_n_in, ~atn_n, ~ifc_n, ~ren_n, ~eoi_n_in,
                ~dav_n};

  // three flops; a change counts once stages two and three agree
  always_ff @(posedge sys_clk)
  begin
    s1_q <= raw;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // per-bit agreement filter
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      stable_q <= '0;
    else
      stable_q <= (s2_q & s3_q) | (stable_q & (s2_q | s3_q));
  end

  logic [7:0] bus_data;                  // data lines, true-high
  gpib_decoder_pkg::uniline_t uni;       // uniline lines, true-high
  logic       dav;                       // data valid, true-high
  assign bus_data = stable_q[12:5];
  assign uni      = '{atn: stable_q[4], ifc: stable_q[3],
                      ren: stable_q[2], eoi: stable_q[1]};
  assign dav      = stable_q[0];

  // address guard: out-of-range setting is clamped to the top value
  logic [4:0] my_addr;                   // effective address
  logic [4:0] addr_q;                    // last seen address
  logic       addr_chg;                  // setting changed
  assign my_addr  = (primary_addr > gpib_decoder_pkg::addr_max)
                    ? gpib_decoder_pkg::addr_max : primary_addr;
  assign addr_chg = (my_addr != addr_q);

  // track address to spot changes
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      addr_q <= gpib_decoder_pkg::addr_reset;
    else
      addr_q <= my_addr;
  end

  // acceptor handshake
  gpib_decoder_pkg::ah_state_t ah_q;     // acceptor state
  logic       take;                      // byte taken this cycle
  logic [7:0] latch_q;                   // captured byte
  logic       latch_atn_q;               // captured attention
  logic       latch_eoi_q;               // captured end flag
  logic       latch_new_q;               // captured byte awaits decode
  logic       acc_ok;                    // able to accept now

  // a data byte only stalls on the sink when it will go out
  assign acc_ok = uni.atn || !listen_addr || sink_ready;
  assign take   = (ah_q == gpib_decoder_pkg::ah_ready) && dav;

  // ready, capture on data valid, release not-accepted, wait for drop
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      ah_q <= gpib_decoder_pkg::ah_idle;
    else
      unique case (ah_q)
        gpib_decoder_pkg::ah_idle:
          if (!dav && acc_ok)
            ah_q <= gpib_decoder_pkg::ah_ready;
        gpib_decoder_pkg::ah_ready:
          if (dav)
            ah_q <= gpib_decoder_pkg::ah_accept;
          else if (!acc_ok)
            ah_q <= gpib_decoder_pkg::ah_idle;
        gpib_decoder_pkg::ah_accept:
          ah_q <= gpib_decoder_pkg::ah_wait_release;
        gpib_decoder_pkg::ah_wait_release:
          if (!dav)
            ah_q <= gpib_decoder_pkg::ah_idle;
      endcase
  end

  // capture the byte with its attention and end qualifiers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      latch_q     <= 8'h00;
      latch_atn_q <= 1'b0;
      latch_eoi_q <= 1'b0;
      latch_new_q <= 1'b0;
    end
    else
    begin
      latch_new_q <= take;
      if (take)
      begin
        latch_q     <= bus_data;
        latch_atn_q <= uni.atn;
        latch_eoi_q <= uni.eoi;
      end
    end
  end

  // handshake drives: ready released only in ready, accepted after take
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      nrfd_n_out <= 1'b0;
      nrfd_n_oe  <= 1'b0;
      ndac_n_out <= 1'b0;
      ndac_n_oe  <= 1'b0;
    end
    else
    begin
      // open drain: enable low pulls low, high releases
      nrfd_n_out <= 1'b0;
      ndac_n_out <= 1'b0;
      nrfd_n_oe  <= (ah_q == gpib_decoder_pkg::ah_ready) && !dav && acc_ok;
      ndac_n_oe  <= (ah_q == gpib_decoder_pkg::ah_accept) ||
                    (ah_q == gpib_decoder_pkg::ah_wait_release);
    end
  end

  // command decode on the low seven bits
  logic [6:0] cmd7;                      // command without top bit
  logic       is_cmd;                    // byte under attention
  logic       my_listen;                 // own listen address
  logic       my_talk;                   // own talk address
  logic       other_talk;                // another talk address
  logic       do_clear;                  // reset to defaults
  logic       do_local;                  // go to local
  assign cmd7       = latch_q[6:0];
  assign is_cmd     = latch_new_q && latch_atn_q;
  assign my_listen  = is_cmd && cmd7 == (gpib_decoder_pkg::listen_or
                      | {2'b00, my_addr});
  assign my_talk    = is_cmd && cmd7 == (gpib_decoder_pkg::talk_or
                      | {2'b00, my_addr});
  assign other_talk = is_cmd && cmd7[6:5] == gpib_decoder_pkg::grp_talk
                      && !my_talk && cmd7 != gpib_decoder_pkg::cmd_untalk;
  // secondary, parallel poll and take control fall through
  assign do_clear   = is_cmd && (cmd7 == gpib_decoder_pkg::cmd_dev_clear
                      || (listen_addr &&
                          cmd7 == gpib_decoder_pkg::cmd_sel_clear));
  assign do_local   = is_cmd && listen_addr &&
                      cmd7 == gpib_decoder_pkg::cmd_go_local;

  logic bus_reset;                       // interface-wide reset
  assign bus_reset = rst || addr_chg || !uni.ren;

  // remote enable a cycle back; a level test would undo go-to-local
  logic ren_q;                           // filtered remote enable, delayed
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      ren_q <= 1'b0;
    else
      ren_q <= uni.ren;
  end

  // remote on new remote enable or own listen; local sticks till then
  always_ff @(posedge sys_clk)
  begin
    if (bus_reset)
      remote <= 1'b0;
    else if (do_local)
      remote <= 1'b0;
    else if (uni.ren && (!ren_q || my_listen))
      remote <= 1'b1;
  end

  // local lockout: universal, optional clear on go-to-local
  always_ff @(posedge sys_clk)
  begin
    if (bus_reset)
      local_lockout <= 1'b0;
    else if (is_cmd && cmd7 == gpib_decoder_pkg::cmd_lockout)
      local_lockout <= 1'b1;
    else if (do_local && gtl_unlocks)
      local_lockout <= 1'b0;
  end

  // panel gating from lockout and configured remote lock
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      panel_locked  <= 1'b0;
      local_key_off <= 1'b0;
    end
    else
    begin
      panel_locked  <= local_lockout || (remote && lockout_cfg);
      local_key_off <= local_lockout;
    end
  end

  // listener addressing; interface clear wins over everything
  always_ff @(posedge sys_clk)
  begin
    if (bus_reset || uni.ifc)
      listen_addr <= 1'b0;
    else if (is_cmd && cmd7 == gpib_decoder_pkg::cmd_unlisten)
      listen_addr <= 1'b0;
    else if (my_listen)
      listen_addr <= 1'b1;
  end

  // talker addressing
  always_ff @(posedge sys_clk)
  begin
    if (bus_reset || uni.ifc)
      talk_addr <= 1'b0;
    else if (is_cmd && cmd7 == gpib_decoder_pkg::cmd_untalk)
      talk_addr <= 1'b0;
    else if (other_talk)
      talk_addr <= 1'b0;
    else if (my_talk)
      talk_addr <= 1'b1;
  end

  // serial poll mode
  always_ff @(posedge sys_clk)
  begin
    if (bus_reset || uni.ifc)
      serial_poll <= 1'b0;
    else if (is_cmd && cmd7 == gpib_decoder_pkg::cmd_poll_on)
      serial_poll <= 1'b1;
    else if (is_cmd && cmd7 == gpib_decoder_pkg::cmd_poll_off)
      serial_poll <= 1'b0;
  end

  // action pulses to the instrument
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      clear_pulse   <= 1'b0;
      trigger_pulse <= 1'b0;
    end
    else
    begin
      clear_pulse   <= do_clear;
      trigger_pulse <= is_cmd && cmd7 == gpib_decoder_pkg::cmd_trigger
                       && (listen_addr || trig_any);
    end
  end

  // data path: attention false and listening, end flag travels along
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      data_byte  <= 8'h00;
      data_valid <= 1'b0;
      data_end   <= 1'b0;
    end
    else
    begin
      data_valid <= latch_new_q && !latch_atn_q && listen_addr;
      if (latch_new_q && !latch_atn_q)
      begin
        data_byte <= latch_q;
        data_end  <= latch_eoi_q;
      end
    end
  end

  // service request: set wins over serviced, held until serviced
  logic srq_q;                           // pending request
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      srq_q <= 1'b0;
    else if (need_service)
      srq_q <= 1'b1;
    else if (serviced)
      srq_q <= 1'b0;
  end

  // device drives only its own request line, never attention lines
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      srq_n_out <= 1'b0;
      srq_n_oe  <= 1'b1;
    end
    else
    begin
      srq_n_out <= 1'b0;
      srq_n_oe  <= !srq_q;
    end
  end

endmodule : gpib_bus_command_decoder

// >>> logic/gpib_decoder_pkg.sv
// package: command codes, reset values and carriers for the bus decoder
package gpib_decoder_pkg;

  // multiline command codes, low seven bits only
  localparam logic [6:0] cmd_go_local      = 7'h01;
  localparam logic [6:0] cmd_sel_clear     = 7'h04;
  localparam logic [6:0] cmd_trigger       = 7'h08;
  localparam logic [6:0] cmd_lockout       = 7'h11;
  localparam logic [6:0] cmd_dev_clear     = 7'h14;
  localparam logic [6:0] cmd_poll_on       = 7'h18;
  localparam logic [6:0] cmd_poll_off      = 7'h19;
  localparam logic [6:0] cmd_unlisten      = 7'h3f;
  localparam logic [6:0] cmd_untalk        = 7'h5f;
  // group bases: bits 6:5 select the group
  localparam logic [1:0] grp_listen        = 2'h1;
  localparam logic [1:0] grp_talk          = 2'h2;
  localparam logic [1:0] grp_second        = 2'h3;
  localparam logic [6:0] listen_or         = 7'h20;
  localparam logic [6:0] talk_or           = 7'h40;
  // highest legal primary address
  localparam logic [4:0] addr_max          = 5'h1e;
  localparam logic [4:0] addr_reset        = 5'h00;
  // synchroniser depth for bus pins
  localparam int         sync_stages       = 3;

  // uniline levels, already inverted to true-high
  typedef struct packed {
    logic atn;
    logic ifc;
    logic ren;
    logic eoi;
  } uniline_t;

  // interface state seen by the instrument
  typedef struct packed {
    logic remote;
    logic lockout;
    logic listen;
    logic talk;
    logic poll;
  } bus_state_t;

  // acceptor handshake states
  typedef enum logic [1:0] {
    ah_idle,
    ah_ready,
    ah_accept,
    ah_wait_release
  } ah_state_t;

endpackage : gpib_decoder_pkg
